// file: shared/power_seq_cfg.svh
// Constants of the channel sequencer
`ifndef POWER_SEQ_CFG_SVH
`define POWER_SEQ_CFG_SVH
`define CLK_PERIOD_NS 50
`define DEGLITCH_NS 10000
`define DEGLITCH_CYC ((`DEGLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FAST_STEP_NS 1000
`define FAST_STEP_CYC ((`FAST_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RATIO_FRAC_BITS 8
`define DAC_WIDTH 10
`define VOLT_WIDTH 16
`define TIMER_WIDTH 16
`define FAST_NEAR_CODES 16'h0010
`define CONNECT_TOL 1
`endif

// file: shared/power_seq_pkg.sv
// Types of the channel sequencer
package power_seq_pkg;
	typedef enum logic [6:0] {
		ST_OFF = 7'h01,
		ST_ON_DLY = 7'h02,
		ST_RISE = 7'h04,
		ST_ON = 7'h08,
		ST_MARG_HI = 7'h10,
		ST_MARG_LO = 7'h20,
		ST_OFF_DLY = 7'h40
	} chan_state_t;
	typedef enum logic [1:0] {
		ON_BY_VIN = 2'h0, ON_BY_OP = 2'h1, ON_BY_CTL = 2'h2, ON_BY_BOTH = 2'h3
	} on_src_t;
	typedef enum logic [1:0] {
		DAC_SOFT = 2'h0, DAC_DISC = 2'h1, DAC_MAN_SOFT = 2'h2, DAC_MAN_HARD = 2'h3
	} dac_mode_t;
	typedef enum logic [1:0] {
		MARG_NONE = 2'h0, MARG_LOW = 2'h1, MARG_HIGH = 2'h2
	} margin_t;
endpackage : power_seq_pkg

// file: shared/servo_if.sv
// Link between sequencer and trim servo
`timescale 1ns/100ps
`default_nettype none
interface servo_if #(parameter int DW = 10, parameter int VW = 16);
	logic [VW-1:0] target, reading, ovWarn, uvWarn;
	logic readValid, connectReq, continuous, onWarn, fastOff;
	logic manual, hard, manualWr, connected;
	logic [DW-1:0] manualCode, fbCode, dacCode;
	modport ctl(output target, reading, ovWarn, uvWarn, readValid,
		connectReq, continuous, onWarn, fastOff, manual, hard, manualWr,
		manualCode, fbCode, input dacCode, connected);
	modport srv(input target, reading, ovWarn, uvWarn, readValid,
		connectReq, continuous, onWarn, fastOff, manual, hard, manualWr,
		manualCode, fbCode, output dacCode, connected);
endinterface : servo_if
`default_nettype wire

// file: hdl/trim_servo.sv
// Trim DAC servo and soft or hard connect
`timescale 1ns/100ps
`default_nettype none
`include "power_seq_cfg.svh"
module trim_servo import power_seq_pkg::*; #(
	parameter int DW = `DAC_WIDTH,
	parameter int FAST_CYC = `FAST_STEP_CYC
) (
	input wire logic core_clk, // Core clock
	input wire logic rst_b, // Async reset, active low
	servo_if.srv s // Sequencer side
);
	logic [DW-1:0] dacReg;
	logic connReg, activeReg, fastReg;
	logic [`VOLT_WIDTH-1:0] lastTgt;
	logic [15:0] fastCnt;
	logic [DW-1:0] fbDiff;
	logic [`VOLT_WIDTH-1:0] err;
	logic fbUp, readLow, readHigh, tgtChg, newConn, warnOut, fastTick;
	assign fbUp = s.fbCode > dacReg;
	assign fbDiff = fbUp ? s.fbCode - dacReg : dacReg - s.fbCode;
	assign readLow = s.reading < s.target;
	assign readHigh = s.reading > s.target;
	assign err = readLow ? s.target - s.reading : s.reading - s.target;
	assign tgtChg = s.target != lastTgt;
	assign warnOut = (s.reading > s.ovWarn) || (s.reading < s.uvWarn);
	assign fastTick = fastCnt == 16'h0000;
	assign newConn = s.connectReq && !connReg &&
		((s.manual && s.hard) || fbDiff <= DW'(`CONNECT_TOL));
	assign s.dacCode = dacReg;
	assign s.connected = connReg;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) connReg <= 1'b0;
		else if (!s.connectReq) connReg <= 1'b0;
		else if (newConn) connReg <= 1'b1;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) lastTgt <= 16'h0000;
		else lastTgt <= s.target;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) fastCnt <= 16'h0000;
		else if (fastTick) fastCnt <= 16'(FAST_CYC - 1);
		else fastCnt <= fastCnt - 16'h0001;
	end

	// Servo runs again on target change, new connect, or warn drift
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) activeReg <= 1'b0;
		else if (tgtChg || newConn || s.continuous) activeReg <= 1'b1;
		else if (s.onWarn && s.readValid && warnOut) activeReg <= 1'b1;
		else if (s.readValid && !readLow && !readHigh) activeReg <= 1'b0;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) fastReg <= 1'b0;
		else if (!s.fastOff && !s.manual && (tgtChg || newConn))
			fastReg <= 1'b1;
		else if (!connReg || (s.readValid && err <= `FAST_NEAR_CODES))
			fastReg <= 1'b0;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) dacReg <= '0;
		else if (!connReg) begin
			if (s.connectReq && s.manual && s.hard) dacReg <= s.manualCode;
			else if (fbUp) dacReg <= dacReg + 1'b1;
			else if (fbDiff != '0) dacReg <= dacReg - 1'b1;
		end else if (s.manual) begin
			if (s.manualWr) dacReg <= s.manualCode;
		end else if (fastReg) begin
			if (fastTick && readLow && dacReg != '1) dacReg <= dacReg + 1'b1;
			else if (fastTick && readHigh && dacReg != '0)
				dacReg <= dacReg - 1'b1;
		end else if (activeReg && s.readValid) begin
			if (readLow && dacReg != '1) dacReg <= dacReg + 1'b1;
			else if (readHigh && dacReg != '0) dacReg <= dacReg - 1'b1;
		end
	end

	property p_manual_hold;
		@(posedge core_clk) disable iff (!rst_b)
		connReg && s.manual && !s.manualWr && $past(connReg) && s.connectReq
		|=> $stable(dacReg);
	endproperty
	a_manual_hold: assert property (p_manual_hold)
		else $error("manual DAC moved without a write");
	property p_soft_match;
		@(posedge core_clk) disable iff (!rst_b)
		$rose(connReg) && !s.hard |-> $past(fbDiff) <= DW'(`CONNECT_TOL);
	endproperty
	a_soft_match: assert property (p_soft_match)
		else $error("soft connect closed away from feedback code");
	property p_hard_code;
		@(posedge core_clk) disable iff (!rst_b)
		$rose(connReg) && s.manual && s.hard |-> dacReg == $past(s.manualCode);
	endproperty
	a_hard_code: assert property (p_hard_code)
		else $error("hard connect did not load manual code");
endmodule : trim_servo
`default_nettype wire

// file: hdl/power_channel_sequencer.sv
// One power channel: on and off sequencing, margin and trim control
`timescale 1ns/100ps
`default_nettype none
`include "power_seq_cfg.svh"
module power_channel_sequencer import power_seq_pkg::*; #(
	parameter int DW = `DAC_WIDTH,
	parameter int VW = `VOLT_WIDTH,
	parameter int TW = `TIMER_WIDTH,
	parameter int DEGLITCH_CYC = `DEGLITCH_CYC,
	parameter int FAST_CYC = `FAST_STEP_CYC
) (
	input wire logic core_clk, // Core clock, 20 MHz
	input wire logic rst_b, // Async reset, active low
	input wire logic vinAboveOn, // Input sense above on level
	input wire logic vinBelowOff, // Input sense below off level
	input wire logic controlPin, // Control pin, async, active high
	input wire on_src_t onSrc, // Turn-on source
	input wire logic opCmdValid, // Operation command pulse
	input wire logic opCmdOn, // Operation: on
	input wire margin_t opMargin, // Operation: margin select
	input wire logic opGlobal, // Operation sent to all pages
	input wire logic [TW-1:0] tonDelay, // On delay, cycles
	input wire logic [TW-1:0] tonRise, // Rise time, cycles
	input wire logic [TW-1:0] tonMaxFault, // UV check time, cycles
	input wire logic [TW-1:0] toffDelay, // Off delay, cycles
	input wire logic uvFaultEnable, // UV at check time faults off
	input wire logic faultRespEnable, // React to shared fault line
	input wire logic ignoreOvMargin, // Skip OV check while margining
	input wire logic [VW-1:0] voutReading, // Output reading
	input wire logic voutValid, // New output reading pulse
	input wire logic [VW-1:0] voutCommand, // Nominal target
	input wire logic [VW-1:0] marginHigh, // Margin high target
	input wire logic [VW-1:0] marginLow, // Margin low target
	input wire logic [VW-1:0] ovFaultLimit, // OV fault limit
	input wire logic [VW-1:0] uvFaultLimit, // UV fault limit
	input wire logic [VW-1:0] ovWarnLimit, // OV warn limit
	input wire logic [VW-1:0] uvWarnLimit, // UV warn limit
	input wire logic [7:0] dischargeRatio, // Off level ratio, /256
	input wire logic continuousTrim, // Servo config bit 7
	input wire logic servoOnWarn, // Servo config bit 6
	input wire logic fastServoOff, // Fast servo disabled
	input wire dac_mode_t dacMode, // DAC connect mode
	input wire logic [DW-1:0] manualDacCode, // Manual DAC code
	input wire logic manualDacWr, // Manual code write pulse
	input wire logic [DW-1:0] feedbackCode, // Feedback node as code
	input wire logic clearFaults, // Clear status pulse
	input wire logic faultLineIn, // Shared fault line level
	output logic faultLineOut, // Shared fault line drive value
	output logic faultLineOe, // Driving fault line low
	output logic convEnable, // Converter enable
	output logic [DW-1:0] trimDacOut, // Trim DAC code
	output logic trimDacOe, // DAC connected, else high Z
	output logic alertOutN, // Alert, active low
	output logic vendorStatusReg, // Held off above discharge level
	output logic ovFaultFlag, // Sticky OV fault
	output logic uvFaultFlag, // Sticky UV fault
	output chan_state_t chanState // Channel state
);
	servo_if #(.DW(DW), .VW(VW)) sv ();
	chan_state_t stateReg, stateNext;
	logic [TW-1:0] timerReg;
	logic ctlMeta, ctlSync, fltMeta, fltSync;
	logic [15:0] dglCnt;
	logic faultTrip, vinOk, opOn, faultLatch, forceConn, riseDone;
	logic onSel, onCond, inMargin, inOnGroup, ovNow, uvAtMax, overThresh;
	logic immOff, marginReq, uvTrip;
	logic [VW+7:0] threshProd;

	// Pin synchronisers
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctlMeta <= 1'b0;
			ctlSync <= 1'b0;
			fltMeta <= 1'b1;
			fltSync <= 1'b1;
		end else begin
			ctlMeta <= controlPin;
			ctlSync <= ctlMeta;
			fltMeta <= faultLineIn;
			fltSync <= fltMeta;
		end
	end

	// Own drive is not taken as an outside fault
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) dglCnt <= 16'h0000;
		else if (fltSync || faultLineOe) dglCnt <= 16'h0000;
		else if (dglCnt != 16'(DEGLITCH_CYC)) dglCnt <= dglCnt + 16'h0001;
	end
	assign faultTrip = faultRespEnable &&
		dglCnt == 16'(DEGLITCH_CYC);

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) vinOk <= 1'b0;
		else if (vinBelowOff) vinOk <= 1'b0;
		else if (vinAboveOn) vinOk <= 1'b1;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) opOn <= 1'b0;
		else if (opCmdValid) opOn <= opCmdOn;
	end

	always_comb begin
		case (onSrc)
			ON_BY_VIN: onSel = 1'b1;
			ON_BY_OP: onSel = opOn;
			ON_BY_CTL: onSel = ctlSync;
			default: onSel = opOn && ctlSync;
		endcase
	end
	assign onCond = vinOk && onSel;

	assign inMargin = stateReg == ST_MARG_HI || stateReg == ST_MARG_LO;
	assign inOnGroup = inMargin || stateReg == ST_ON;
	assign ovNow = voutValid && voutReading > ovFaultLimit &&
		!(inMargin && ignoreOvMargin);
	assign uvAtMax = voutReading < uvFaultLimit;
	assign threshProd = dischargeRatio * voutCommand;
	assign overThresh = voutReading >=
		threshProd[VW+`RATIO_FRAC_BITS-1:`RATIO_FRAC_BITS];
	assign immOff = vinBelowOff || faultTrip || ovNow;
	assign marginReq = opCmdValid && opCmdOn && opMargin != MARG_NONE;

	always_comb begin
		stateNext = stateReg;
		if (immOff) stateNext = ST_OFF;
		else begin
			case (stateReg)
				ST_OFF: begin
					if (onCond && !faultLatch && !overThresh)
						stateNext = ST_ON_DLY;
				end
				ST_ON_DLY: begin
					if (!onCond) stateNext = ST_OFF;
					else if (timerReg >= tonDelay) stateNext = ST_RISE;
				end
				ST_RISE: begin
					if (!onCond) stateNext = ST_OFF_DLY;
					else if (timerReg >= tonMaxFault)
						stateNext = (uvAtMax && uvFaultEnable) ? ST_OFF : ST_ON;
				end
				ST_ON, ST_MARG_HI, ST_MARG_LO: begin
					if (!onCond) stateNext = ST_OFF_DLY;
					else if (opCmdValid && opCmdOn) begin
						if (opMargin == MARG_HIGH) stateNext = ST_MARG_HI;
						else if (opMargin == MARG_LOW) stateNext = ST_MARG_LO;
						else stateNext = ST_ON;
					end
				end
				ST_OFF_DLY: begin
					if (timerReg >= toffDelay) stateNext = ST_OFF;
				end
				default: stateNext = ST_OFF;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) stateReg <= ST_OFF;
		else stateReg <= stateNext;
	end
	assign chanState = stateReg;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) timerReg <= '0;
		else if (stateNext != stateReg) timerReg <= '0;
		else if (timerReg != '1) timerReg <= timerReg + 1'b1;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) convEnable <= 1'b0;
		else convEnable <= stateNext == ST_RISE || stateNext == ST_ON ||
			stateNext == ST_MARG_HI || stateNext == ST_MARG_LO ||
			stateNext == ST_OFF_DLY;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) riseDone <= 1'b0;
		else if (stateReg != ST_RISE) riseDone <= 1'b0;
		else if (timerReg >= tonRise) riseDone <= 1'b1;
	end

	// Latched UV fault drives shared line until on request drops
	assign uvTrip = stateReg == ST_RISE && stateNext == ST_OFF && !immOff &&
		onCond;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) faultLatch <= 1'b0;
		else if (uvTrip) faultLatch <= 1'b1;
		else if (!onCond) faultLatch <= 1'b0;
	end
	assign faultLineOe = faultLatch;
	assign faultLineOut = 1'b0;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) forceConn <= 1'b0;
		else if (marginReq && !opGlobal && inOnGroup && dacMode == DAC_DISC)
			forceConn <= 1'b1;
		else if (!inOnGroup || stateNext == ST_ON) forceConn <= 1'b0;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) vendorStatusReg <= 1'b0;
		else if (stateReg == ST_OFF && onCond && !faultLatch && overThresh)
			vendorStatusReg <= 1'b1;
		else if (clearFaults) vendorStatusReg <= 1'b0;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) ovFaultFlag <= 1'b0;
		else if (ovNow) ovFaultFlag <= 1'b1;
		else if (clearFaults) ovFaultFlag <= 1'b0;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) uvFaultFlag <= 1'b0;
		else if (uvTrip) uvFaultFlag <= 1'b1;
		else if (clearFaults) uvFaultFlag <= 1'b0;
	end
	assign alertOutN = !(vendorStatusReg || ovFaultFlag || uvFaultFlag);

	always_comb begin
		case (stateReg)
			ST_MARG_HI: sv.target = marginHigh;
			ST_MARG_LO: sv.target = marginLow;
			default: sv.target = voutCommand;
		endcase
	end
	// Margin keeps a live DAC connected
	assign sv.connectReq = (inOnGroup || riseDone) && (dacMode != DAC_DISC ||
		forceConn || (inMargin && sv.connected));
	assign sv.reading = voutReading;
	assign sv.readValid = voutValid;
	assign sv.ovWarn = ovWarnLimit;
	assign sv.uvWarn = uvWarnLimit;
	assign sv.continuous = continuousTrim;
	assign sv.onWarn = servoOnWarn && !continuousTrim;
	assign sv.fastOff = fastServoOff;
	assign sv.manual = dacMode == DAC_MAN_SOFT || dacMode == DAC_MAN_HARD;
	assign sv.hard = dacMode == DAC_MAN_HARD;
	assign sv.manualWr = manualDacWr;
	assign sv.manualCode = manualDacCode;
	assign sv.fbCode = feedbackCode;
	assign trimDacOut = sv.dacCode;
	assign trimDacOe = sv.connected;

	trim_servo #(.DW(DW), .FAST_CYC(FAST_CYC)) servo (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.s(sv.srv)
	);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	property p_vin_gate;
		stateReg == ST_OFF && !vinOk |=> stateReg == ST_OFF;
	endproperty
	a_vin_gate: assert property (p_vin_gate)
		else $error("channel left off without input voltage");
	property p_vin_drop;
		vinBelowOff |=> stateReg == ST_OFF && !convEnable;
	endproperty
	a_vin_drop: assert property (p_vin_drop)
		else $error("input drop did not turn channel off");
	property p_on_delay;
		$rose(convEnable) |-> $past(stateReg) == ST_ON_DLY &&
			$past(timerReg) >= $past(tonDelay);
	endproperty
	a_on_delay: assert property (p_on_delay)
		else $error("enable rose before on delay");
	property p_rise_connect;
		$rose(sv.connectReq) && !inOnGroup |-> $past(timerReg) >= tonRise;
	endproperty
	a_rise_connect: assert property (p_rise_connect)
		else $error("DAC connect before rise time");
	property p_uv_fault;
		stateReg == ST_RISE && timerReg >= tonMaxFault && uvAtMax &&
		uvFaultEnable && onCond && !immOff |=> faultLineOe ##0 !convEnable;
	endproperty
	a_uv_fault: assert property (p_uv_fault)
		else $error("UV at check time not faulted");
	property p_ov_check;
		voutValid && voutReading > ovFaultLimit && !inMargin
		|=> stateReg == ST_OFF ##0 ovFaultFlag;
	endproperty
	a_ov_check: assert property (p_ov_check)
		else $error("OV not acted on");
	property p_off_delay;
		$fell(convEnable) && $past(stateReg) == ST_OFF_DLY && !$past(immOff)
		|-> $past(timerReg) >= $past(toffDelay);
	endproperty
	a_off_delay: assert property (p_off_delay)
		else $error("enable fell before off delay");
	property p_discharge;
		stateReg == ST_OFF && onCond && !faultLatch && overThresh && !immOff
		|=> stateReg == ST_OFF ##0 vendorStatusReg ##0 !alertOutN;
	endproperty
	a_discharge: assert property (p_discharge)
		else $error("discharge hold not flagged");
	property p_fault_line;
		faultRespEnable && !faultLineOe [*8] ##0 dglCnt == 16'(DEGLITCH_CYC)
		|=> stateReg == ST_OFF;
	endproperty
	a_fault_line: assert property (p_fault_line)
		else $error("deglitched fault line ignored");
	property p_no_disc_margin;
		inMargin && sv.connected && inMargin |=> !inMargin || sv.connected;
	endproperty
	a_no_disc_margin: assert property (p_no_disc_margin)
		else $error("DAC dropped while margining");

	c_reach_on: cover property (stateReg == ST_RISE ##1 stateReg == ST_ON);
	c_margin_hi: cover property (stateReg == ST_MARG_HI && trimDacOe);
	c_off_seq: cover property (stateReg == ST_OFF_DLY ##1 stateReg == ST_OFF);
	c_trip: cover property (faultTrip);
endmodule : power_channel_sequencer
`default_nettype wire

// file: tb/converter_model.sv
// Converter model: output voltage, readings and feedback node
`timescale 1ns/100ps
`default_nettype none
module converter_model #(
	parameter int NOM = 1000
) (
	input wire logic core_clk, // Clock
	input wire logic rst_b, // Reset, active low
	input wire logic convEnable, // Enable from channel
	input wire logic [9:0] trimDacOut, // Trim code
	input wire logic trimDacOe, // Trim connected
	output logic [15:0] voutReading, // Output reading
	output logic voutValid, // Reading pulse
	output logic [9:0] feedbackCode // Feedback node as code
);
	int vout;
	int tgt;
	logic [1:0] div;
	assign feedbackCode = 10'h200;
	always_comb begin
		tgt = trimDacOe ? NOM + int'(trimDacOut) - 512 : NOM;
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			vout <= 0;
			div <= 2'h0;
			voutValid <= 1'b0;
			voutReading <= 16'h0000;
		end else begin
			div <= div + 2'h1;
			voutValid <= (div == 2'h3);
			if (div == 2'h3)
				voutReading <= 16'(vout);
			// Slow decay when disabled
			if (!convEnable)
				vout <= (vout > 2) ? vout - 2 : 0;
			else
				vout <= (vout + 8 < tgt) ? vout + 8 : tgt;
		end
	end
endmodule : converter_model
`default_nettype wire

// file: tb/tb_power_channel_sequencer.sv
// Self-checking bench of the power channel sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_power_channel_sequencer import power_seq_pkg::*;;
	localparam int THR = (128 * 1000) / 256;
	logic core_clk = 0, rst_b = 0, vinAboveOn = 0, vinBelowOff = 0;
	logic controlPin = 0, opCmdValid = 0, opCmdOn = 0, extFaultN = 1;
	logic continuousTrim = 1, servoOnWarn = 0, clearFaults = 0;
	on_src_t onSrc = ON_BY_CTL;
	margin_t opMargin = MARG_NONE;
	dac_mode_t dacMode = DAC_SOFT;
	logic [15:0] tonDelay = 16'h0003, toffDelay = 16'h0003;
	logic [15:0] ovFaultLimit = 16'hFFFF, tonRise = 16'h0004;
	logic [15:0] tonMaxFault = 16'h00C8, uvFaultLimit = 16'h0100;
	logic [15:0] voutCommand = 16'h03E8, marginHigh = 16'h044C;
	logic [15:0] marginLow = 16'h0384;
	logic [7:0] dischargeRatio = 8'h80;
	logic opGlobal = 0, manualDacWr = 0, faultRespEnable = 1;
	logic [9:0] manualDacCode = 10'h000;
	logic [7:0] lfsrState = 8'h31;
	logic faultLineIn, faultLineOut, faultLineOe, convEnable, trimDacOe;
	logic alertOutN, vendorStatusReg, ovFaultFlag, uvFaultFlag, voutValid;
	logic [9:0] trimDacOut, feedbackCode;
	logic [15:0] voutReading;
	chan_state_t chanState;
	int errors = 0, n_checks = 0, n, m;
	margin_t plan[$] = '{MARG_HIGH, MARG_LOW, MARG_NONE};
	// Open-drain fault line
	assign faultLineIn = extFaultN & ~faultLineOe;
	always #25 core_clk = ~core_clk;
	power_channel_sequencer #(.DEGLITCH_CYC(8), .FAST_CYC(2))
		i_power_channel_sequencer (
		.core_clk(core_clk), .rst_b(rst_b), .vinAboveOn(vinAboveOn),
		.vinBelowOff(vinBelowOff), .controlPin(controlPin), .onSrc(onSrc),
		.opCmdValid(opCmdValid), .opCmdOn(opCmdOn), .opMargin(opMargin),
		.opGlobal(opGlobal), .tonDelay(tonDelay), .tonRise(tonRise),
		.tonMaxFault(tonMaxFault), .toffDelay(toffDelay), .uvFaultEnable(1'b1),
		.faultRespEnable(faultRespEnable), .ignoreOvMargin(1'b0),
		.voutReading(voutReading), .voutValid(voutValid),
		.voutCommand(voutCommand), .marginHigh(marginHigh),
		.marginLow(marginLow),
		.ovFaultLimit(ovFaultLimit), .uvFaultLimit(uvFaultLimit),
		.ovWarnLimit(16'h0BB8), .uvWarnLimit(16'h0320),
		.dischargeRatio(dischargeRatio), .continuousTrim(continuousTrim),
		.servoOnWarn(servoOnWarn), .fastServoOff(1'b0), .dacMode(dacMode),
		.manualDacCode(manualDacCode), .manualDacWr(manualDacWr),
		.feedbackCode(feedbackCode), .clearFaults(clearFaults),
		.faultLineIn(faultLineIn), .faultLineOut(faultLineOut),
		.faultLineOe(faultLineOe), .convEnable(convEnable),
		.trimDacOut(trimDacOut), .trimDacOe(trimDacOe), .alertOutN(alertOutN),
		.vendorStatusReg(vendorStatusReg), .ovFaultFlag(ovFaultFlag),
		.uvFaultFlag(uvFaultFlag), .chanState(chanState));
	converter_model i_converter_model (.core_clk(core_clk), .rst_b(rst_b),
		.convEnable(convEnable), .trimDacOut(trimDacOut), .trimDacOe(trimDacOe),
		.voutReading(voutReading), .voutValid(voutValid),
		.feedbackCode(feedbackCode));
	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : report_and_stop
	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s exp %0h seen %0h", name, exp, seen);
		end
	endtask : check
	task automatic tick();
		@(posedge core_clk);
		#1;
	endtask : tick
	// Counts cycles until a probe holds: 0 enable, 1 dac on, 2 disable, 3 state
	task automatic waitUntil(input int k, input chan_state_t s, input int lim,
		output int cnt);
		logic hit;
		cnt = 0;
		hit = 1'b0;
		while (!hit && cnt < lim) begin
			tick();
			cnt++;
			hit = (k == 0) ? convEnable === 1'b1 : (k == 1) ? trimDacOe === 1'b1 :
				(k == 2) ? convEnable === 1'b0 : chanState === s;
		end
		check("wait", hit, 1'b1);
	endtask : waitUntil
	task automatic op(input logic on, input margin_t mg);
		@(posedge core_clk);
		opCmdValid <= 1'b1;
		opCmdOn <= on;
		opMargin <= mg;
		opGlobal <= mg == MARG_HIGH;
		@(posedge core_clk);
		opCmdValid <= 1'b0;
		#1;
	endtask : op
	function automatic logic [7:0] nextLfsr(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction : nextLfsr
	initial begin
		repeat (5) @(posedge core_clk);
		rst_b <= 1'b1;
		#1;
		check("state", chanState, ST_OFF);
		check("enable", convEnable, 1'b0);
		check("alert", alertOutN, 1'b1);
		@(posedge core_clk) controlPin <= 1'b1;
		repeat (10) tick();
		check("state", chanState, ST_OFF);
		@(posedge core_clk);
		lfsrState = nextLfsr(lfsrState);
		onSrc <= ON_BY_BOTH;
		vinAboveOn <= 1'b1;
		tonDelay <= {13'h0000, lfsrState[2:0]} + 16'h0001;
		toffDelay <= {13'h0000, lfsrState[5:3]} + 16'h0001;
		continuousTrim <= lfsrState[6];
		servoOnWarn <= lfsrState[7];
		manualDacCode <= {lfsrState, 2'h0};
		repeat (10) tick();
		check("state", chanState, ST_OFF);
		op(1'b1, MARG_NONE);
		waitUntil(3, ST_ON_DLY, 4, n);
		waitUntil(0, ST_OFF, 20, n);
		check("onDelay", n, tonDelay + 16'h0001);
		check("state", chanState, ST_RISE);
		waitUntil(3, ST_ON, 400, m);
		check("maxFault", m, tonMaxFault + 16'h0001);
		check("uv", uvFaultFlag, 1'b0);
		waitUntil(1, ST_OFF, 2000, n);
		check("late", (m + n) > 5, 1'b1);
		check("match", trimDacOut >= 10'h1FF && trimDacOut <= 10'h201, 1'b1);
		foreach (plan[i]) begin
			op(1'b1, plan[i]);
			check("margin", chanState, (plan[i] == MARG_HIGH) ? ST_MARG_HI :
				(plan[i] == MARG_LOW) ? ST_MARG_LO : ST_ON);
			if (plan[i] != MARG_NONE) begin
				repeat (1500) tick();
				check("target", voutReading, (plan[i] == MARG_HIGH) ? marginHigh :
					marginLow);
			end
			if (plan[i] == MARG_HIGH) begin
				@(posedge core_clk) dacMode <= DAC_DISC;
				repeat (4) tick();
				check("noDisc", trimDacOe, 1'b1);
			end
		end
		repeat (4) tick();
		check("hiZ", trimDacOe, 1'b0);
		@(posedge core_clk) controlPin <= 1'b0;
		waitUntil(3, ST_OFF_DLY, 6, n);
		waitUntil(2, ST_OFF, 20, n);
		check("offDelay", n, toffDelay + 16'h0001);
		@(posedge core_clk) controlPin <= 1'b1;
		repeat (6) tick();
		check("held", chanState, ST_OFF);
		check("vendor", vendorStatusReg, 1'b1);
		check("alert", alertOutN, 1'b0);
		waitUntil(3, ST_ON_DLY, 1000, n);
		check("decayed", int'(voutReading) < THR, 1'b1);
		@(posedge core_clk) clearFaults <= 1'b1;
		@(posedge core_clk) clearFaults <= 1'b0;
		tick();
		check("cleared", alertOutN, 1'b1);
		waitUntil(3, ST_ON, 1000, n);
		@(posedge core_clk) extFaultN <= 1'b0;
		repeat (4) @(posedge core_clk);
		extFaultN <= 1'b1;
		repeat (12) tick();
		check("glitch", chanState, ST_ON);
		@(posedge core_clk) extFaultN <= 1'b0;
		repeat (6) tick();
		check("deglitch", chanState, ST_ON);
		waitUntil(3, ST_OFF, 10, n);
		check("faultOff", n >= 2 && n <= 6, 1'b1);
		check("enable", convEnable, 1'b0);
		@(posedge core_clk) extFaultN <= 1'b1;
		waitUntil(3, ST_ON, 3000, n);
		@(posedge core_clk) dacMode <= DAC_MAN_HARD;
		repeat (2) tick();
		check("hard", trimDacOut, manualDacCode);
		check("hardOe", trimDacOe, 1'b1);
		@(posedge core_clk) manualDacWr <= 1'b1;
		manualDacCode <= 10'h2A5;
		@(posedge core_clk) manualDacWr <= 1'b0;
		repeat (8) tick();
		check("manual", trimDacOut, 10'h2A5);
		@(posedge core_clk) vinBelowOff <= 1'b1;
		tick();
		check("vinOff", chanState, ST_OFF);
		check("enable", convEnable, 1'b0);
		@(posedge core_clk) vinBelowOff <= 1'b0;
		waitUntil(3, ST_ON, 3000, n);
		@(posedge core_clk) clearFaults <= 1'b1;
		@(posedge core_clk) clearFaults <= 1'b0;
		tick();
		check("cleared", alertOutN, 1'b1);
		@(posedge core_clk) ovFaultLimit <= 16'h0010;
		waitUntil(3, ST_OFF, 12, n);
		check("ov", ovFaultFlag, 1'b1);
		check("alert", alertOutN, 1'b0);
		report_and_stop();
	end
	initial begin
		#(20000 * 50);
		errors++;
		report_and_stop();
	end
endmodule : tb_power_channel_sequencer
`default_nettype wire
